// ---- common/bpcks_map.svh ----
// Register map, field positions and reset values of the pixel back-end.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef BPCKS_MAP_SVH
`define BPCKS_MAP_SVH

// ==========================================================
// Register byte offsets
`define BPCKS_A_CLIP0_MIN    8'h00
`define BPCKS_A_CLIP0_MAX    8'h04
`define BPCKS_A_CLIP1_MIN    8'h08
`define BPCKS_A_CLIP1_MAX    8'h0C
`define BPCKS_A_SKEY_LO      8'h10
`define BPCKS_A_SKEY_HI      8'h14
`define BPCKS_A_DKEY_LO      8'h18
`define BPCKS_A_DKEY_HI      8'h1C
`define BPCKS_A_ROPS         8'h20
`define BPCKS_A_DASH_CTL     8'h24
`define BPCKS_A_DASH_PAT     8'h28
`define BPCKS_A_ERR_A        8'h2C
`define BPCKS_A_ERR_B        8'h30
`define BPCKS_A_STATUS       8'h34

// ==========================================================
// Field masks and positions
`define BPCKS_CLIP_MASK      32'h0FFF_0FFF
`define BPCKS_KEY_MASK       32'h00FF_FFFF
`define BPCKS_ROP_MASK       32'h00FF_FFFF
`define BPCKS_DASH_MASK      32'h1FFF_1FFF
`define BPCKS_ERR_MASK       32'h8000_FFFF
`define BPCKS_RESET_VAL      32'h0000_0000
`define BPCKS_ERR_USE_BIT    31

`endif

// ---- common/bpcks_pkg.sv ----
// Types shared by the pixel back-end.
// Assumes bpcks_map.svh is on the include path.
package bpcks_pkg;
  typedef enum logic [2:0] {
    BPCKS_BPP8  = 3'h1,
    BPCKS_BPP16 = 3'h3,
    BPCKS_BPP24 = 3'h4,
    BPCKS_BPP32 = 3'h5
  } bpcks_bpp_t;
endpackage : bpcks_pkg

// ---- verif/tb_bpcks_pixel_backend.sv ----
// Self-checking bench for the pixel back-end: registers, clip, keys, rops, stipple.
// Assumes bpcks_map.svh on the include path and bpcks_pkg compiled first.
`timescale 1ns/100ps
`include "bpcks_map.svh"

module tb_bpcks_pixel_backend;
  import bpcks_pkg::*;
  logic             mclk, reset, wbCyc, wbStb, wbWe, wb_ack_o;
  logic [7:0]       wbAdr;
  logic [31:0]      wbDat, wb_dat_o, rd, srcColour, dstColour, fgCol, bgCol;
  logic             engineBusy, clipSelect, srcKeyEnable, dstKeyEnable, transparentMode;
  logic             pixValid, pixIsLine, outValid, outWrite, errAUse, errBUse, fgBit;
  logic [7:0]       ropDefault, outRop, cnt;
  bpcks_bpp_t       srcBpp, dstBpp;
  logic [11:0]      pixX, pixY;
  logic [31:0]      outColour;
  logic [15:0]      errATerm, errBTerm;
  logic [4:0]       bitI;
  logic [31:0]      patExp = 32'h0000_0006;
  logic [7:0]       ropExp [4] = '{8'h11, 8'h55, 8'hAA, 8'hCC};
  int               err_count = 0;
  int               n_tests = 0;

  bpcks_pixel_backend i_bpcks_pixel_backend (.mclk(mclk), .reset(reset), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .engineBusy(engineBusy), .clipSelect(clipSelect),
    .srcKeyEnable(srcKeyEnable), .dstKeyEnable(dstKeyEnable), .transparentMode(transparentMode),
    .ropDefault(ropDefault), .srcBpp(srcBpp), .dstBpp(dstBpp), .pixValid(pixValid),
    .pixIsLine(pixIsLine), .pixX(pixX), .pixY(pixY), .srcColour(srcColour),
    .dstColour(dstColour), .foreground_colour(fgCol), .background_colour(bgCol),
    .outValid(outValid), .outWrite(outWrite), .outColour(outColour), .outRop(outRop),
    .errAUse(errAUse), .errATerm(errATerm), .errBUse(errBUse), .errBTerm(errBTerm));

  // ==========================================================
  // Shared tasks
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  // Classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    if (n == 20) begin
      err_count++;
      end_of_test();
    end
  endtask : wb

  task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask : rdChk

  // One pixel; outputs sampled in the cycle they stand
  task automatic pixel(input logic [11:0] x, input logic [11:0] y, input logic line);
    @(posedge mclk);
    pixX <= x; pixY <= y; pixIsLine <= line; pixValid <= 1'b1;
    @(posedge mclk);
    pixValid <= 1'b0;
    #1;
    chk("outValid", 32'h1, {31'h0, outValid});
  endtask : pixel

  task automatic clipChk(input logic s, input logic [11:0] x, input logic [11:0] y, input logic e);
    clipSelect <= s;
    pixel(x, y, 1'b0);
    chk("outWrite", {31'h0, e}, {31'h0, outWrite});
  endtask : clipChk

  // ==========================================================
  // Clock, reset and sequence
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    reset = 1'b1; wbCyc = 0; wbStb = 0; wbWe = 0; wbAdr = 0; wbDat = 0; engineBusy = 0;
    clipSelect = 0; srcKeyEnable = 0; dstKeyEnable = 0; transparentMode = 0;
    ropDefault = 8'h11; srcBpp = BPCKS_BPP32; dstBpp = BPCKS_BPP32; pixValid = 0;
    pixIsLine = 0; pixX = 0; pixY = 0; srcColour = 32'hFF30_3040; dstColour = 32'h0030_3040;
    fgCol = 32'h00AB_CDEF; bgCol = 32'h0012_3456;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    wb(1'b1, `BPCKS_A_CLIP0_MIN, 32'hFFFF_FFFF);
    rdChk("clipSet0Min", `BPCKS_A_CLIP0_MIN, 32'h0FFF_0FFF);
    rdChk("unmapped", 8'h3C, 32'h0000_0000);
    wb(1'b1, `BPCKS_A_ERR_A, 32'hFFFF_FFFF);
    rdChk("errA", `BPCKS_A_ERR_A, 32'h8000_FFFF);
    chk("errA", 32'h0001_FFFF, {15'h0, errAUse, errATerm});
    wb(1'b1, `BPCKS_A_ERR_A, 32'h0000_1234);
    chk("errA", 32'h0000_1234, {15'h0, errAUse, errATerm});
    wb(1'b1, `BPCKS_A_ERR_B, 32'hFFFE_8001);
    chk("errB", 32'h0001_8001, {15'h0, errBUse, errBTerm});
    engineBusy <= 1'b1;
    rdChk("status", `BPCKS_A_STATUS, 32'h0000_0001);
    engineBusy <= 1'b0;
    wb(1'b1, `BPCKS_A_CLIP0_MIN, 32'h0003_0002);
    wb(1'b1, `BPCKS_A_CLIP0_MAX, 32'h0008_000A);
    wb(1'b1, `BPCKS_A_CLIP1_MIN, 32'h0000_0000);
    wb(1'b1, `BPCKS_A_CLIP1_MAX, 32'h0005_0005);
    clipChk(0, 9, 7, 1);
    clipChk(0, 10, 7, 0);
    clipChk(0, 2, 3, 1);
    clipChk(0, 1, 3, 0);
    clipChk(0, 9, 8, 0);
    clipChk(1, 4, 4, 1);
    clipChk(1, 9, 7, 0);
    clipSelect <= 1'b0;
    // Whole-word compare would pass 0x301050; channel compare must not
    wb(1'b1, `BPCKS_A_SKEY_LO, 32'h0020_2030);
    wb(1'b1, `BPCKS_A_SKEY_HI, 32'h0040_5060);
    wb(1'b1, `BPCKS_A_DKEY_LO, 32'h0020_2030);
    wb(1'b1, `BPCKS_A_DKEY_HI, 32'h0040_5060);
    wb(1'b1, `BPCKS_A_ROPS, 32'h00CC_AA55);
    for (int i = 0; i < 4; i++) begin
      srcKeyEnable <= i[1];
      dstKeyEnable <= i[0];
      pixel(4, 4, 1'b0);
      chk("rop", {24'h0, ropExp[i]}, {24'h0, outRop});
    end
    srcBpp <= BPCKS_BPP24;
    srcColour <= 32'h0030_1050;
    pixel(4, 4, 1'b0);
    chk("rop", 32'h0000_0055, {24'h0, outRop});
    srcBpp <= BPCKS_BPP8;
    pixel(4, 4, 1'b0);
    chk("rop", 32'h0000_00CC, {24'h0, outRop});
    // 565: 0x3090 is inside the word range but green is above its bound
    srcBpp <= BPCKS_BPP16;
    wb(1'b1, `BPCKS_A_SKEY_HI, 32'h0040_507F);
    srcColour <= 32'h0000_3090;
    pixel(4, 4, 1'b0);
    chk("rop", 32'h0000_0055, {24'h0, outRop});
    srcColour <= 32'h0000_3050;
    pixel(4, 4, 1'b0);
    chk("rop", 32'h0000_00CC, {24'h0, outRop});
    // Pattern 110, three bits, two pixels a bit, start bit 0 with offset 1
    wb(1'b1, `BPCKS_A_DASH_PAT, patExp);
    wb(1'b1, `BPCKS_A_DASH_CTL, 32'h0001_0201);
    bitI = 5'd0;
    cnt = 8'd1;
    for (int i = 0; i < 12; i++) begin
      transparentMode <= (i >= 8);
      fgBit = patExp[bitI];
      pixel(4, 4, 1'b1);
      chk("colour", fgBit ? fgCol : bgCol, outColour);
      chk("lineWrite", {31'h0, fgBit | (i < 8)}, {31'h0, outWrite});
      if (cnt == 8'd1) begin
        cnt = 8'd0;
        bitI = (bitI == 5'd2) ? 5'd0 : bitI + 5'd1;
      end else begin
        cnt = cnt + 8'd1;
      end
      if (i == 7) begin
        rdChk("position", `BPCKS_A_DASH_CTL, {3'h0, bitI, cnt, 16'h0201});
      end
    end
    transparentMode <= 1'b0;
    // Reload to bit 2 so the result differs from the position left behind
    wb(1'b1, `BPCKS_A_DASH_CTL, 32'h0200_0201);
    rdChk("reload", `BPCKS_A_DASH_CTL, 32'h0200_0201);
    pixel(4, 4, 1'b1);
    chk("colour", fgCol, outColour);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
endmodule : tb_bpcks_pixel_backend

// ---- verilog/bpcks_pixel_backend.sv ----
// Pixel back-end: clip, colour keys, keyed rop select, line stipple, error overrides.
// Assumes the drawing loop is on mclk and pulses pixValid once per pixel.
//
// Functional notes
// RL1 - Two clip rectangles held; command clip-select picks which one gates writes.
// RL2 - Write only when min <= x < max and min <= y < max.
// RL3 - Clip registers: x in bits 11:0, y in bits 27:16, rest reserved.
// RL4 - Source key passes when colour within inclusive 24-bit min/max range; code compares R, G, B (index at 8bpp) separately, not the whole word.
// RL5 - Destination key passes when colour within inclusive min/max range.
// RL6 - 8bpp compares index whole; other depths compare R, G, B separately.
// RL7 - At 32bpp the top byte is ignored for keying.
// RL8 - Disabled keying forces that key test to fail.
// RL9 - Software must not enable source keying with 1bpp source.
// RL10 - Rop0 on fail/fail, rop1 dest pass, rop2 src pass, rop3 both.
// RL11 - Stipple size holds length minus one; pattern repeats every 1..32 bits.
// RL12 - Repeat count holds pixels per bit minus one, 1..256 pixels.
// RL13 - Start has bit index and fraction; first bit covers repeat+1-fraction pixels.
// RL14 - Software keeps start index <= size and fraction <= repeat count.
// RL15 - Writing dash control reloads position; else lines continue from last.
// RL16 - Reading dash control when idle returns the next line's position.
// RL17 - Set bit draws foreground; clear draws background or skips if transparent.
// RL18 - Per pixel: counter==repeat clears and advances index with wrap, else increments.
// RL19 - Pattern bits numbered from lsb, pattern in low-order bits.
// RL20 - Error register bit 31 selects supplied signed term over computed one.
// RL21 - Software should clear bit 31 after a supplied-term operation.
// RL22 - Error a serves lines, left edges, y stretch; b right edges, x stretch.
// RL23 - Error b holds signed term in 15:0, use flag in bit 31.
`timescale 1ns/100ps
`include "bpcks_map.svh"

module bpcks_pixel_backend #(
  parameter int CW = 12
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  engineBusy,
  input  wire logic                  clipSelect,
  input  wire logic                  srcKeyEnable,
  input  wire logic                  dstKeyEnable,
  input  wire logic                  transparentMode,
  input  wire logic [7:0]            ropDefault,
  input  wire bpcks_pkg::bpcks_bpp_t srcBpp,
  input  wire bpcks_pkg::bpcks_bpp_t dstBpp,
  input  wire logic                  pixValid,
  input  wire logic                  pixIsLine,
  input  wire logic [CW-1:0]         pixX,
  input  wire logic [CW-1:0]         pixY,
  input  wire logic [31:0]           srcColour,
  input  wire logic [31:0]           dstColour,
  input  wire logic [31:0]           foreground_colour,
  input  wire logic [31:0]           background_colour,
  output logic                       outValid,
  output logic                       outWrite,
  output logic [31:0]                outColour,
  output logic [7:0]                 outRop,
  output logic                       errAUse,
  output logic [15:0]                errATerm,
  output logic                       errBUse,
  output logic [15:0]                errBTerm
);
  import bpcks_pkg::*;

  // ==========================================================
  // Register bus
  logic [31:0] clipSet0Min_ff, clipSet0Max_ff, clipSet1Min_ff, clipSet1Max_ff;
  logic [31:0] skeyLo_ff, skeyHi_ff, dkeyLo_ff, dkeyHi_ff;
  logic [31:0] rops_ff, dashCtl_ff, dashPat_ff, errA_ff, errB_ff;
  logic [4:0]  bitIdx_ff;
  logic [7:0]  pixCnt_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;

  wire        busReq  = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        busWr   = busReq & wb_we_i;
  wire [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] sm, input logic [31:0] fm);
    merge = ((old & ~sm) | (nw & sm)) & fm;
  endfunction : merge

  wire wClip0Min = busWr && wb_adr_i == `BPCKS_A_CLIP0_MIN;
  wire wClip0Max = busWr && wb_adr_i == `BPCKS_A_CLIP0_MAX;
  wire wClip1Min = busWr && wb_adr_i == `BPCKS_A_CLIP1_MIN;
  wire wClip1Max = busWr && wb_adr_i == `BPCKS_A_CLIP1_MAX;
  wire wSkeyLo   = busWr && wb_adr_i == `BPCKS_A_SKEY_LO;
  wire wSkeyHi   = busWr && wb_adr_i == `BPCKS_A_SKEY_HI;
  wire wDkeyLo   = busWr && wb_adr_i == `BPCKS_A_DKEY_LO;
  wire wDkeyHi   = busWr && wb_adr_i == `BPCKS_A_DKEY_HI;
  wire wRops     = busWr && wb_adr_i == `BPCKS_A_ROPS;
  wire wDashCtl  = busWr && wb_adr_i == `BPCKS_A_DASH_CTL;
  wire wDashPat  = busWr && wb_adr_i == `BPCKS_A_DASH_PAT;
  wire wErrA     = busWr && wb_adr_i == `BPCKS_A_ERR_A;
  wire wErrB     = busWr && wb_adr_i == `BPCKS_A_ERR_B;

  // Live position when idle; mid-line value is indeterminate anyway
  wire [31:0] dashRead = {3'b000, bitIdx_ff, pixCnt_ff, dashCtl_ff[15:0]};  // [RL16]

  // Unmapped addresses read zero and still ack, so the master never hangs
  wire [31:0] rdMux =
      (wb_adr_i == `BPCKS_A_CLIP0_MIN) ? clipSet0Min_ff :
      (wb_adr_i == `BPCKS_A_CLIP0_MAX) ? clipSet0Max_ff :
      (wb_adr_i == `BPCKS_A_CLIP1_MIN) ? clipSet1Min_ff :
      (wb_adr_i == `BPCKS_A_CLIP1_MAX) ? clipSet1Max_ff :
      (wb_adr_i == `BPCKS_A_SKEY_LO)   ? skeyLo_ff :
      (wb_adr_i == `BPCKS_A_SKEY_HI)   ? skeyHi_ff :
      (wb_adr_i == `BPCKS_A_DKEY_LO)   ? dkeyLo_ff :
      (wb_adr_i == `BPCKS_A_DKEY_HI)   ? dkeyHi_ff :
      (wb_adr_i == `BPCKS_A_ROPS)      ? rops_ff :
      (wb_adr_i == `BPCKS_A_DASH_CTL)  ? dashRead :
      (wb_adr_i == `BPCKS_A_DASH_PAT)  ? dashPat_ff :
      (wb_adr_i == `BPCKS_A_ERR_A)     ? errA_ff :
      (wb_adr_i == `BPCKS_A_ERR_B)     ? errB_ff :
      (wb_adr_i == `BPCKS_A_STATUS)    ? {31'h0000_0000, engineBusy} :
      `BPCKS_RESET_VAL;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_ff  <= 1'b0;
      rdat_ff <= `BPCKS_RESET_VAL;
    end else begin
      ack_ff  <= busReq;
      rdat_ff <= busReq ? rdMux : rdat_ff;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clipSet0Min_ff <= `BPCKS_RESET_VAL;
      clipSet0Max_ff <= `BPCKS_RESET_VAL;
      clipSet1Min_ff <= `BPCKS_RESET_VAL;
      clipSet1Max_ff <= `BPCKS_RESET_VAL;
      skeyLo_ff   <= `BPCKS_RESET_VAL;
      skeyHi_ff   <= `BPCKS_RESET_VAL;
      dkeyLo_ff   <= `BPCKS_RESET_VAL;
      dkeyHi_ff   <= `BPCKS_RESET_VAL;
      rops_ff     <= `BPCKS_RESET_VAL;
      dashCtl_ff  <= `BPCKS_RESET_VAL;
      dashPat_ff  <= `BPCKS_RESET_VAL;
      errA_ff     <= `BPCKS_RESET_VAL;
      errB_ff     <= `BPCKS_RESET_VAL;
    end else begin
      if (wClip0Min) clipSet0Min_ff <=
          merge(clipSet0Min_ff, wb_dat_i, selMask, `BPCKS_CLIP_MASK);  // [RL3]
      if (wClip0Max) clipSet0Max_ff <=
          merge(clipSet0Max_ff, wb_dat_i, selMask, `BPCKS_CLIP_MASK);  // [RL3]
      if (wClip1Min) clipSet1Min_ff <=
          merge(clipSet1Min_ff, wb_dat_i, selMask, `BPCKS_CLIP_MASK);  // [RL3]
      if (wClip1Max) clipSet1Max_ff <=
          merge(clipSet1Max_ff, wb_dat_i, selMask, `BPCKS_CLIP_MASK);  // [RL3]
      if (wSkeyLo)   skeyLo_ff   <= merge(skeyLo_ff, wb_dat_i, selMask, `BPCKS_KEY_MASK);
      if (wSkeyHi)   skeyHi_ff   <= merge(skeyHi_ff, wb_dat_i, selMask, `BPCKS_KEY_MASK);
      if (wDkeyLo)   dkeyLo_ff   <= merge(dkeyLo_ff, wb_dat_i, selMask, `BPCKS_KEY_MASK);
      if (wDkeyHi)   dkeyHi_ff   <= merge(dkeyHi_ff, wb_dat_i, selMask, `BPCKS_KEY_MASK);
      if (wRops)     rops_ff     <= merge(rops_ff, wb_dat_i, selMask, `BPCKS_ROP_MASK);
      if (wDashCtl)  dashCtl_ff  <= merge(dashCtl_ff, wb_dat_i, selMask, `BPCKS_DASH_MASK);
      if (wDashPat)  dashPat_ff  <= merge(dashPat_ff, wb_dat_i, selMask, 32'hFFFF_FFFF);
      if (wErrA)     errA_ff     <= merge(errA_ff, wb_dat_i, selMask, `BPCKS_ERR_MASK);
      if (wErrB)     errB_ff     <= merge(errB_ff, wb_dat_i, selMask, `BPCKS_ERR_MASK); // [RL23]
    end
  end

  // ==========================================================
  // Error-term overrides
  assign errAUse  = errA_ff[`BPCKS_ERR_USE_BIT];  // [RL20] [RL22]
  assign errATerm = errA_ff[15:0];                // [RL22]
  assign errBUse  = errB_ff[`BPCKS_ERR_USE_BIT];  // [RL20] [RL23]
  assign errBTerm = errB_ff[15:0];                // [RL23]

  // ==========================================================
  // Clip test
  wire [31:0] clipMin = clipSelect ? clipSet1Min_ff : clipSet0Min_ff;   // [RL1]
  wire [31:0] clipMax = clipSelect ? clipSet1Max_ff : clipSet0Max_ff;   // [RL1]
  wire [11:0] xMin = clipMin[11:0];
  wire [11:0] yMin = clipMin[27:16];
  wire [11:0] xMax = clipMax[11:0];
  wire [11:0] yMax = clipMax[27:16];
  wire [11:0] px12 = 12'(pixX);
  wire [11:0] py12 = 12'(pixY);
  wire inClip = (px12 >= xMin) && (px12 < xMax)
             && (py12 >= yMin) && (py12 < yMax);                   // [RL2]

  // ==========================================================
  // Colour keys
  function automatic logic keyInRange(input logic [31:0] c, input logic [31:0] lo,
                                      input logic [31:0] hi, input bpcks_bpp_t bpp);
    logic ok;
    ok = 1'b1;
    if (bpp == BPCKS_BPP8) begin
      ok = (c[7:0] >= lo[7:0]) && (c[7:0] <= hi[7:0]);             // [RL6]
    end else if (bpp == BPCKS_BPP16) begin
      ok = (c[15:11] >= lo[15:11]) && (c[15:11] <= hi[15:11])
        && (c[10:5] >= lo[10:5]) && (c[10:5] <= hi[10:5])
        && (c[4:0] >= lo[4:0]) && (c[4:0] <= hi[4:0]);             // [RL6]
    end else begin
      // Bits 31:24 never looked at, so alpha is ignored
      ok = (c[23:16] >= lo[23:16]) && (c[23:16] <= hi[23:16])
        && (c[15:8] >= lo[15:8]) && (c[15:8] <= hi[15:8])
        && (c[7:0] >= lo[7:0]) && (c[7:0] <= hi[7:0]);             // [RL6] [RL7]
    end
    keyInRange = ok;
  endfunction : keyInRange

  wire srcPass = srcKeyEnable
              && keyInRange(srcColour, skeyLo_ff, skeyHi_ff, srcBpp);   // [RL4] [RL8]
  wire dstPass = dstKeyEnable
              && keyInRange(dstColour, dkeyLo_ff, dkeyHi_ff, dstBpp);   // [RL5] [RL8]

  wire [7:0] ropSel = (srcPass && dstPass) ? rops_ff[23:16] :
                      srcPass              ? rops_ff[15:8] :
                      dstPass              ? rops_ff[7:0] :
                                             ropDefault;          // [RL10]

  // ==========================================================
  // Line stipple
  wire [7:0] repCnt  = dashCtl_ff[7:0];       // [RL12]
  wire [4:0] maskSz  = dashCtl_ff[12:8];      // [RL11]
  wire       patBit  = dashPat_ff[bitIdx_ff]; // [RL19]
  wire       linePix = pixValid && pixIsLine;
  wire [4:0] startIdx  = wb_dat_i[28:24];     // [RL13]
  wire [7:0] startFrac = wb_dat_i[23:16];     // [RL13]

  wire [4:0] nxt_bitIdx = (bitIdx_ff == maskSz) ? 5'h00 : 5'(bitIdx_ff + 5'h01); // [RL11]
  wire       cntWrap    = (pixCnt_ff == repCnt);                                  // [RL18]

  // Fraction preloads the counter, so the first bit lasts repeat+1-fraction pixels
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bitIdx_ff <= 5'h00;
      pixCnt_ff <= 8'h00;
    end else if (wDashCtl) begin
      bitIdx_ff <= startIdx;                                     // [RL13] [RL15]
      pixCnt_ff <= startFrac;                                    // [RL13] [RL15]
    end else if (linePix) begin
      bitIdx_ff <= cntWrap ? nxt_bitIdx : bitIdx_ff;             // [RL18]
      pixCnt_ff <= cntWrap ? 8'h00 : 8'(pixCnt_ff + 8'h01);      // [RL12] [RL18]
    end
  end

  // ==========================================================
  // Pixel output
  wire skipPix   = pixIsLine && !patBit && transparentMode;      // [RL17]
  wire [31:0] lineCol = patBit ? foreground_colour : background_colour; // [RL17]

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      outValid  <= 1'b0;
      outWrite  <= 1'b0;
      outColour <= `BPCKS_RESET_VAL;
      outRop    <= 8'h00;
    end else begin
      outValid  <= pixValid;
      outWrite  <= pixValid && inClip && !skipPix;               // [RL2] [RL17]
      outColour <= pixIsLine ? lineCol : srcColour;
      outRop    <= ropSel;                                       // [RL10]
    end
  end

  // ==========================================================
  // Checks
  property p_clip_gate;
    @(posedge mclk) disable iff (reset)
      (pixValid && !inClip) |=> !outWrite;
  endproperty : p_clip_gate
  a_clip_gate: assert property (p_clip_gate)  // [RL2]
    else $error("write outside clip");

  // Looks at the raw set-1 register, not at the selected bounds
  property p_clip1_sel;
    @(posedge mclk) disable iff (reset)
      (pixValid && clipSelect && (px12 >= clipSet1Max_ff[11:0])) |=> !outWrite;
  endproperty : p_clip1_sel
  a_clip1_sel: assert property (p_clip1_sel)  // [RL1]
    else $error("clip set 1 not applied");

  property p_key_off;
    @(posedge mclk) disable iff (reset)
      (pixValid && !srcKeyEnable && !dstKeyEnable) |=> (outRop == $past(ropDefault));
  endproperty : p_key_off
  a_key_off: assert property (p_key_off)  // [RL8] [RL10]
    else $error("default rop not used with keys off");

  property p_skip_write;
    @(posedge mclk) disable iff (reset)
      (pixValid && pixIsLine && transparentMode && !patBit) |=> !outWrite;
  endproperty : p_skip_write
  a_skip_write: assert property (p_skip_write)  // [RL17]
    else $error("transparent stipple pixel written");

  property p_line_fore;
    @(posedge mclk) disable iff (reset)
      (pixValid && pixIsLine && patBit) |=> (outColour == $past(foreground_colour));
  endproperty : p_line_fore
  a_line_fore: assert property (p_line_fore)  // [RL17]
    else $error("set stipple bit not in foreground");

  property p_line_back;
    @(posedge mclk) disable iff (reset)
      (pixValid && pixIsLine && !patBit) |=> (outColour == $past(background_colour));
  endproperty : p_line_back
  a_line_back: assert property (p_line_back)  // [RL17]
    else $error("clear stipple bit not in background");

  property p_dash_reload;
    @(posedge mclk) disable iff (reset)
      wDashCtl |=> (bitIdx_ff == $past(startIdx)) && (pixCnt_ff == $past(startFrac));
  endproperty : p_dash_reload
  a_dash_reload: assert property (p_dash_reload)  // [RL13] [RL15]
    else $error("stipple position not reloaded");

  property p_dash_hold;
    @(posedge mclk) disable iff (reset)
      (!wDashCtl && !linePix) |=> $stable(bitIdx_ff) && $stable(pixCnt_ff);
  endproperty : p_dash_hold
  a_dash_hold: assert property (p_dash_hold)  // [RL15]
    else $error("stipple position moved without a line pixel");

  property p_dash_step;
    @(posedge mclk) disable iff (reset)
      (linePix && !wDashCtl && !cntWrap)
        |=> (pixCnt_ff == 8'($past(pixCnt_ff) + 8'h01)) && $stable(bitIdx_ff);
  endproperty : p_dash_step
  a_dash_step: assert property (p_dash_step)  // [RL18]
    else $error("pixel counter did not step");

  property p_dash_adv;
    @(posedge mclk) disable iff (reset)
      (linePix && !wDashCtl && cntWrap && (bitIdx_ff != maskSz))
        |=> (bitIdx_ff == 5'($past(bitIdx_ff) + 5'h01)) && (pixCnt_ff == 8'h00);
  endproperty : p_dash_adv
  a_dash_adv: assert property (p_dash_adv)  // [RL18]
    else $error("bit index did not advance");

  property p_dash_wrap;
    @(posedge mclk) disable iff (reset)
      (linePix && !wDashCtl && cntWrap && (bitIdx_ff == maskSz))
        |=> (bitIdx_ff == 5'h00) && (pixCnt_ff == 8'h00);
  endproperty : p_dash_wrap
  a_dash_wrap: assert property (p_dash_wrap)  // [RL11] [RL18]
    else $error("bit index did not wrap after stipple size");

  property p_out_valid;
    @(posedge mclk) disable iff (reset)
      pixValid |=> outValid;
  endproperty : p_out_valid
  a_out_valid: assert property (p_out_valid)
    else $error("pixel result missing");

  property p_out_idle;
    @(posedge mclk) disable iff (reset)
      !pixValid |=> (!outValid && !outWrite);
  endproperty : p_out_idle
  a_out_idle: assert property (p_out_idle)
    else $error("result without a pixel");

  // Ack must drop even when the master is slow to release
  property p_ack_pulse;
    @(posedge mclk) disable iff (reset)
      wb_ack_o |=> !wb_ack_o;
  endproperty : p_ack_pulse
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  // ==========================================================
  // Coverage
  c_clip_reject: cover property (@(posedge mclk) disable iff (reset)
    pixValid && !inClip);
  c_both_keys: cover property (@(posedge mclk) disable iff (reset)
    pixValid && srcPass && dstPass);
  c_dash_wrap: cover property (@(posedge mclk) disable iff (reset)
    linePix && cntWrap && (bitIdx_ff == maskSz));
  c_line_skip: cover property (@(posedge mclk) disable iff (reset)
    pixValid && skipPix);
endmodule : bpcks_pixel_backend
